/* sleep_gate_pkg.sv */
// constants for the deep-sleep gating and soft reset block
package sleep_gate_pkg;
	localparam logic [11:0] soft_reset_ctrl_zero_off = 12'h040;
	localparam logic [11:0] deep_sleep_gate_two_off = 12'h128;
	localparam logic [11:0] int_status_off = 12'h200;
	localparam logic [11:0] int_mask_off = 12'h204;
	localparam logic [11:0] mode_ctrl_off = 12'h208;
	localparam int dma_unit_gate_bit = 13;
	localparam int port_e_gate_bit = 4;
	localparam int port_a_gate_bit = 0;
	localparam logic [31:0] gate_rw_mask = 32'h0000201f;
	localparam logic [31:0] gate_reset_val = 32'h00000000;
	localparam int controller_area_unit_reset_bit = 24;
	localparam int pwm_unit_reset_bit = 20;
	localparam int adc_unit_reset_bit = 16;
	localparam int watchdog_unit_reset_bit = 3;
	localparam logic [31:0] reset_rw_mask = 32'h01110008;
	localparam logic [31:0] reset_reset_val = 32'h00000000;
	localparam int unit_count = 6;
	localparam int rst_count = 4;
	// interrupt status bits
	localparam int irq_fault_bit = 0;
	localparam int irq_reset_bit = 1;
	localparam logic [31:0] irq_rw_mask = 32'h00000003;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_slverr = 2'b10;
	typedef enum logic [1:0] {mode_run, mode_sleep, mode_deep} power_mode_t;
endpackage

/* gate_select.sv */
// picks the active gate set from power mode and auto-gating select
`timescale 1ns/1ps
module gate_select
	import sleep_gate_pkg::*;
(
	input wire logic [1:0] power_mode,
	input wire logic auto_gating_select,
	input wire logic [5:0] run_gate,
	input wire logic [5:0] sleep_gate,
	input wire logic [5:0] deep_gate,
	output logic [5:0] active_gate
);
	always_comb begin
		active_gate = run_gate;
		if (auto_gating_select && power_mode == mode_sleep) begin
			active_gate = sleep_gate;
		end else if (auto_gating_select && power_mode == mode_deep) begin
			active_gate = deep_gate;
		end
	end
endmodule // gate_select

/* deep_sleep_gate_and_soft_reset.sv */
// deep-sleep clock gate register, soft reset register zero, fault check
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module deep_sleep_gate_and_soft_reset
	import sleep_gate_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] power_mode,
	input wire logic [5:0] run_gate_two,
	input wire logic [5:0] sleep_gate_two,
	input wire logic [31:0] capability_mask_one,
	input wire logic periph_req,
	input wire logic [2:0] periph_sel,
	output logic periph_fault,
	output logic [5:0] unit_clk_en,
	output logic [3:0] unit_reset,
	output logic irq
);
	import sleep_gate_pkg::*;

	// ****************************************
	// register state
	// ****************************************
	logic [31:0] deep_sleep_gate_two_r;
	logic [31:0] soft_reset_ctrl_zero_r;
	logic [31:0] int_status_r;
	logic [31:0] int_mask_r;
	logic auto_gating_select_r;
	logic [5:0] deep_gate;
	logic [5:0] active_gate;
	logic fault_event;
	logic reset_event;

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ****************************************
	// axi write channel
	// ****************************************
	logic aw_held_r;
	logic w_held_r;
	logic [11:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic do_write;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;

	assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
	assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
	assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
	assign do_write = (aw_held_r || (s_axi_awvalid && s_axi_awready)) &&
		(w_held_r || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
	assign wr_hit = wr_addr[11:2] == soft_reset_ctrl_zero_off[11:2] ||
		wr_addr[11:2] == deep_sleep_gate_two_off[11:2] || wr_addr[11:2] == int_status_off[11:2] ||
		wr_addr[11:2] == int_mask_off[11:2] || wr_addr[11:2] == mode_ctrl_off[11:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
			end else begin
				if (s_axi_awvalid && s_axi_awready) aw_held_r <= 1'b1;
				if (s_axi_wvalid && s_axi_wready) w_held_r <= 1'b1;
				if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
			end
			// one write at a time: ready only while idle and not yet taken
			s_axi_awready <= !s_axi_awready && !aw_held_r && !s_axi_bvalid && !do_write && s_axi_awvalid;
			s_axi_wready <= !s_axi_wready && !w_held_r && !s_axi_bvalid && !do_write && s_axi_wvalid;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			deep_sleep_gate_two_r <= gate_reset_val;
		end else if (do_write && wr_addr[11:2] == deep_sleep_gate_two_off[11:2]) begin
			deep_sleep_gate_two_r <= strb_merge(deep_sleep_gate_two_r, wr_data, wr_strb) & gate_rw_mask;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_reset_ctrl_zero_r <= reset_reset_val;
		end else if (do_write && wr_addr[11:2] == soft_reset_ctrl_zero_off[11:2]) begin
			// absent units keep their old bit, so masked writes are no-ops
			soft_reset_ctrl_zero_r <= (strb_merge(soft_reset_ctrl_zero_r, wr_data, wr_strb) & capability_mask_one
				| soft_reset_ctrl_zero_r & ~capability_mask_one) & reset_rw_mask;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			auto_gating_select_r <= 1'b0;
			int_mask_r <= 32'h00000000;
		end else if (do_write && wr_addr[11:2] == mode_ctrl_off[11:2]) begin
			if (wr_strb[0]) auto_gating_select_r <= wr_data[0];
		end else if (do_write && wr_addr[11:2] == int_mask_off[11:2]) begin
			int_mask_r <= strb_merge(int_mask_r, wr_data, wr_strb) & irq_rw_mask;
		end
	end

	logic [31:0] status_clr;
	logic [31:0] status_set;

	assign reset_event = do_write && wr_addr[11:2] == soft_reset_ctrl_zero_off[11:2];
	assign status_clr = (do_write && wr_addr[11:2] == int_status_off[11:2]) ?
		(wr_data & irq_rw_mask) : 32'h00000000;

	always_comb begin
		status_set = 32'h00000000;
		status_set[irq_fault_bit] = fault_event;
		status_set[irq_reset_bit] = reset_event;
	end

	// set wins over write-one-to-clear, so an event racing a clear is never lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_status_r <= 32'h00000000;
		end else begin
			int_status_r <= (int_status_r & ~status_clr) | status_set;
		end
	end

	// ****************************************
	// gating and fault
	// ****************************************
	assign deep_gate = {deep_sleep_gate_two_r[dma_unit_gate_bit],
		deep_sleep_gate_two_r[port_e_gate_bit:port_a_gate_bit]};

	gate_select u_gate_select (
		.power_mode(power_mode),
		.auto_gating_select(auto_gating_select_r),
		.run_gate(run_gate_two),
		.sleep_gate(sleep_gate_two),
		.deep_gate(deep_gate),
		.active_gate(active_gate)
	);

	// periph_sel 0..4 ports a..e, 5 dma; other codes have no unit and fault too
	assign fault_event = periph_req && (periph_sel > 3'd5 || !active_gate[periph_sel]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unit_clk_en <= 6'h00;
			periph_fault <= 1'b0;
		end else begin
			unit_clk_en <= active_gate;
			periph_fault <= fault_event;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unit_reset <= 4'h0;
			irq <= 1'b0;
		end else begin
			unit_reset <= {soft_reset_ctrl_zero_r[controller_area_unit_reset_bit],
				soft_reset_ctrl_zero_r[pwm_unit_reset_bit], soft_reset_ctrl_zero_r[adc_unit_reset_bit],
				soft_reset_ctrl_zero_r[watchdog_unit_reset_bit]};
			irq <= |(int_status_r & int_mask_r);
		end
	end

	// ****************************************
	// axi read channel
	// ****************************************
	logic [31:0] rd_val;
	logic rd_hit;
	always_comb begin
		rd_val = 32'h00000000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr[11:2])
			soft_reset_ctrl_zero_off[11:2]: rd_val = soft_reset_ctrl_zero_r;
			deep_sleep_gate_two_off[11:2]: rd_val = deep_sleep_gate_two_r;
			int_status_off[11:2]: rd_val = int_status_r;
			int_mask_off[11:2]: rd_val = int_mask_r;
			mode_ctrl_off[11:2]: rd_val = {31'h00000000, auto_gating_select_r};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= resp_okay;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_hit ? resp_okay : resp_slverr;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	gate_reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(deep_sleep_gate_two_r & ~gate_rw_mask) == 32'h0) else $error("gate reserved bit set");
	reset_reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(soft_reset_ctrl_zero_r & ~reset_rw_mask) == 32'h0) else $error("reset reserved bit set");
	gate_after_reset_a: assert property (@(posedge aclk) $rose(aresetn) |-> deep_sleep_gate_two_r == 32'h0)
		else $error("gate not zero after reset");
	deep_clk_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(auto_gating_select_r && power_mode == mode_deep) |=> unit_clk_en == $past(deep_gate))
		else $error("deep gate not applied");
	no_auto_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!auto_gating_select_r |=> unit_clk_en == $past(run_gate_two)) else $error("sleep sets used without select");
	gated_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(periph_req && periph_sel <= 3'd5 && !active_gate[periph_sel]) |=> periph_fault)
		else $error("gated access without fault");
	open_no_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(periph_req && periph_sel <= 3'd5 && active_gate[periph_sel]) |=> !periph_fault)
		else $error("fault on clocked unit");
	no_unit_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(periph_req && periph_sel > 3'd5) |=> periph_fault) else $error("access to no unit without fault");
	mask_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(reset_event && !capability_mask_one[watchdog_unit_reset_bit]) |=>
		soft_reset_ctrl_zero_r[watchdog_unit_reset_bit] == $past(soft_reset_ctrl_zero_r[watchdog_unit_reset_bit]))
		else $error("masked reset bit changed");
	reset_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 unit_reset[0] == $past(soft_reset_ctrl_zero_r[watchdog_unit_reset_bit]))
		else $error("watchdog reset not following");
	can_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 unit_reset[3] == $past(soft_reset_ctrl_zero_r[controller_area_unit_reset_bit]))
		else $error("can reset not following");
	adc_pwm_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 unit_reset[2:1] == $past({soft_reset_ctrl_zero_r[pwm_unit_reset_bit],
		soft_reset_ctrl_zero_r[adc_unit_reset_bit]}))
		else $error("pwm or adc reset not following");
	dma_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_write && wr_addr[11:2] == deep_sleep_gate_two_off[11:2] && wr_strb[1]) |=>
		deep_sleep_gate_two_r[dma_unit_gate_bit] == $past(wr_data[dma_unit_gate_bit]))
		else $error("dma gate bit not written");
	deep_cov_c: cover property (@(posedge aclk) auto_gating_select_r && power_mode == mode_deep && |deep_gate);
	fault_cov_c: cover property (@(posedge aclk) periph_fault);
	reset_cov_c: cover property (@(posedge aclk) |unit_reset);
	srst_write_c: cover property (@(posedge aclk) reset_event);
endmodule // deep_sleep_gate_and_soft_reset

/* tb_top.sv */
// self-checking bench for the deep-sleep gate and soft reset block
`timescale 1ns/1ps
module tb_top;
	import sleep_gate_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000, cap = 32'h00000000;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0] pm = 2'b00;
	logic [5:0] rg = 6'h00, sg = 6'h00;
	logic req = 1'b0;
	logic [2:0] psel = 3'h0;
	logic awready, wready, bvalid, arready, rvalid, fault, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d, v, gate_m, srst_m, stat_m;
	logic [5:0] clk_en, en_m;
	logic [3:0] urst;
	int err_count = 0, n_compared = 0, cyc = 0, seed = 32'hbb37b7df;
	deep_sleep_gate_and_soft_reset dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.power_mode(pm), .run_gate_two(rg), .sleep_gate_two(sg), .capability_mask_one(cap),
		.periph_req(req), .periph_sel(psel), .periph_fault(fault), .unit_clk_en(clk_en),
		.unit_reset(urst), .irq(irq));
	initial begin
		forever #20 aclk = ~aclk;
	end
	// ****************************************
	// bus tasks and comparison
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// ready is looked at on the falling edge, so the handshake edge is never raced
	task automatic axw(input logic [11:0] a, input logic [31:0] dat, output logic [1:0] resp);
		logic ha, hw, got;
		got = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dat;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got) begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			got = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (got) bready <= 1'b0;
		end
	endtask
	task automatic axr(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] resp);
		logic ha, got;
		got = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got) begin
			@(negedge aclk);
			ha = arvalid && arready;
			got = rvalid;
			dat = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (got) rready <= 1'b0;
		end
	endtask
	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		axr(a, d, r);
		chk(nm, d, exp);
		chk({nm, " resp"}, {30'h0, r}, {30'h0, resp_okay});
	endtask
	function automatic logic [5:0] exp_en(input logic [1:0] m, input logic s, input logic [31:0] g);
		if (!s || m == 2'd0 || m == 2'd3) return rg;
		if (m == 2'd1) return sg;
		return {g[dma_unit_gate_bit], g[port_e_gate_bit:port_a_gate_bit]};
	endfunction
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk("gate reset", deep_sleep_gate_two_off, gate_reset_val);
		rd_chk("srst reset", soft_reset_ctrl_zero_off, reset_reset_val);
		chk("urst reset", {28'h0, urst}, 32'h0);
		axr(12'h300, d, r);
		chk("unmapped read", d, 32'h0);
		chk("unmapped read resp", {30'h0, r}, {30'h0, resp_slverr});
		axw(12'h30c, 32'hffffffff, r);
		chk("unmapped write", {30'h0, r}, {30'h0, resp_slverr});
		gate_m = 32'h0;
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 32'hffffffff : $random(seed);
			axw(deep_sleep_gate_two_off, v, r);
			gate_m = v & gate_rw_mask;
			rd_chk("gate rw", deep_sleep_gate_two_off, gate_m);
		end
		// byte strobe: only the low byte may change, the dma bit must stay
		wstrb <= 4'h1;
		axw(deep_sleep_gate_two_off, ~gate_m, r);
		gate_m = (gate_m & 32'hffffff00) | (~gate_m & 32'h000000ff & gate_rw_mask);
		rd_chk("gate strobe", deep_sleep_gate_two_off, gate_m);
		wstrb <= 4'hf;
		for (int s = 0; s < 2; s++) begin
			axw(mode_ctrl_off, s, r);
			for (int m = 0; m < 4; m++) begin
				@(posedge aclk);
				pm <= 2'(m);
				rg <= 6'($random(seed));
				sg <= 6'($random(seed));
				repeat (3) @(posedge aclk);
				chk("clk en", {26'h0, clk_en}, {26'h0, exp_en(pm, s[0], gate_m)});
			end
		end
		@(posedge aclk);
		pm <= 2'd2;
		repeat (3) @(posedge aclk);
		en_m = exp_en(2'd2, 1'b1, gate_m);
		chk("deep en", {26'h0, clk_en}, {26'h0, en_m});
		for (int s = 0; s < 8; s++) begin
			psel <= 3'(s);
			req <= 1'b1;
			@(posedge aclk);
			req <= 1'b0;
			#1;
			chk("fault", {31'h0, fault}, {31'h0, (s > 5) ? 1'b1 : !en_m[s]});
			@(posedge aclk);
		end
		stat_m = 32'h1;
		srst_m = 32'h0;
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'hffffffff : $random(seed);
			cap <= (i < 2) ? 32'hffffffff : $random(seed);
			@(posedge aclk);
			axw(soft_reset_ctrl_zero_off, v, r);
			srst_m = (srst_m & ~(cap & reset_rw_mask)) | (v & cap & reset_rw_mask);
			rd_chk("srst rw", soft_reset_ctrl_zero_off, srst_m);
			chk("unit reset", {28'h0, urst}, {28'h0, srst_m[24], srst_m[20], srst_m[16], srst_m[3]});
		end
		stat_m = 32'h3;
		chk("irq masked", {31'h0, irq}, 32'h0);
		axw(int_mask_off, 32'hffffffff, r);
		rd_chk("mask", int_mask_off, irq_rw_mask);
		repeat (2) @(posedge aclk);
		chk("irq on", {31'h0, irq}, 32'h1);
		rd_chk("status", int_status_off, stat_m);
		axw(int_status_off, 32'h1, r);
		rd_chk("status w1c", int_status_off, 32'h2);
		axw(int_status_off, 32'h2, r);
		repeat (2) @(posedge aclk);
		chk("irq off", {31'h0, irq}, 32'h0);
		// second reset in mid-run: gate and soft reset registers and unit resets must fall back to reset values, clock enables to the run gate set
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk("gate second reset", deep_sleep_gate_two_off, gate_reset_val);
		rd_chk("srst second reset", soft_reset_ctrl_zero_off, reset_reset_val);
		chk("urst second reset", {28'h0, urst}, 32'h0);
		chk("clk en second reset", {26'h0, clk_en}, {26'h0, rg});
		stop_test();
	end
endmodule // tb_top
